// [rtl/acsp_pkg.sv]
// constants and types of the converter configuration serial port
// Functional notes
// - reset pin low selects serial register access
// - reset pulse over 10 ns clears registers
// - combined mode configures from mode pins
// - parallel mode: serial clock selects low-speed
// - four enable levels select format and interface
// - mode pins select power state
// - all mode pins high selects multiplexed mode
// - shift on falling clock while enable low
// - every sixteenth falling edge commits word
// - trailing partial word bits are discarded
// - several words per enable period allowed
// - eight address bits then eight data bits
// - serial clock up to 20 MHz, any duty; code samples at 100 MHz, so each clock level must last over 10 ns
// - software reset clears all, self-clears
// - readback bit blocks serial register writes; code still accepts writes to address zero
// - readback shifts addressed register data out
// - serial output tri-stated without readback
// - readback uses dedicated pin, any interface
// - address zero: bit1 soft reset, bit0 readback
// - every register resets to zero
// - reset pin high selects parallel-only mode
package acsp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int HW_RESET_MIN_NS = 10;
  localparam int HW_RESET_MIN_RAW = (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HW_RESET_MIN_CYC = (HW_RESET_MIN_RAW < 1) ? 1 : HW_RESET_MIN_RAW;
  localparam logic [3:0] HW_RESET_MIN_CNT = 4'(HW_RESET_MIN_CYC - 1);
  // synchronised pin bundle layout
  localparam int SYNC_W = 9;
  localparam int SI_HWRST = 0;
  localparam int SI_SCLK = 1;
  localparam int SI_SEN = 2;
  localparam int SI_SERIAL_IN_LINE = 3;
  localparam int SI_M1 = 4;
  localparam int SI_M2 = 5;
  localparam int SI_M3 = 6;
  localparam int SI_LVL = 7;
  // serial word
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam logic [3:0] ADDR_DONE = 4'h7;
  localparam logic [3:0] OUT_SHIFT_FROM = 4'h9;
  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam int CFG_SWRST_BIT = 1;
  localparam int CFG_READBACK_BIT = 0;
  localparam logic [7:0] LOWSPD_ADDR = 8'hEF;
  localparam int LOWSPD_BIT = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  // AXI4-Lite map
  localparam int AXI_AW = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [1:0] WIN_SEL = 2'h1;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam int CTRL_PORT_EN = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int ST_PAR = 0;
  localparam int ST_RB = 1;
  localparam int ST_LOWSPD = 2;
  localparam int ST_OB = 3;
  localparam int ST_LVDS = 4;
  localparam int ST_GPD = 5;
  localparam int ST_ASTBY = 6;
  localparam int ST_MUX = 7;
  localparam int ST_INVAL = 8;
  localparam int ST_WORDS = 16;

  typedef enum logic [2:0] {
    PWR_NORMAL, PWR_GLOBAL_PD, PWR_A_STANDBY, PWR_MUX, PWR_UNAVAIL
  } acsp_pwr_t;

  function automatic acsp_pwr_t acsp_pwr_decode(input logic [2:0] pins);
    unique case (pins)
      3'h0: return PWR_NORMAL;
      3'h4: return PWR_GLOBAL_PD;
      3'h5: return PWR_A_STANDBY;
      3'h7: return PWR_MUX;
      default: return PWR_UNAVAIL;
    endcase
  endfunction
endpackage

// [rtl/acsp_sync.sv]
// two-flop synchronisers for every asynchronous pin
module acsp_sync #(
  parameter int W = 9
) (
  input wire logic aclk,
  input wire logic [W-1:0] raw,
  acsp_sync_if.src sync
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_ff;
      logic s2_ff;
      always_ff @(posedge aclk) begin
        s1_ff <= raw[i];
        s2_ff <= s1_ff;
      end
      assign sync.lvl[i] = s2_ff;
    end
  endgenerate
endmodule // acsp_sync

// [rtl/acsp_sync_if.sv]
// synchronised pin levels passed from the synchroniser to the port logic
interface acsp_sync_if #(parameter int W = 9);
  logic [W-1:0] lvl;
  modport src(output lvl);
  modport dst(input lvl);
endinterface

// [rtl/acsp_top.sv]
// configuration serial port with parallel mode decode and AXI4-Lite access
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
module acsp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [acsp_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [acsp_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hw_reset_pin,
  input wire logic serial_clk_pin,
  input wire logic serial_enable_n,
  input wire logic serial_in_line,
  input wire logic mode_pin_1,
  input wire logic mode_pin_2,
  input wire logic mode_pin_3,
  input wire logic [1:0] sen_level_code,
  output logic serial_out_line,
  output logic serial_out_oe,
  output logic low_speed_en,
  output logic offset_binary,
  output logic lvds_select,
  output logic global_powerdown,
  output logic chan_a_standby,
  output logic mux_mode,
  output logic mode_code_invalid
);
  import acsp_pkg::*;

  acsp_sync_if #(.W(SYNC_W)) sync_bus ();

  acsp_sync #(.W(SYNC_W)) u_sync (
    .aclk(aclk),
    .raw({sen_level_code, mode_pin_3, mode_pin_2, mode_pin_1, serial_in_line,
          serial_enable_n, serial_clk_pin, hw_reset_pin}),
    .sync(sync_bus.src)
  );

  wire hw_rst_s = sync_bus.lvl[SI_HWRST];
  wire sclk_s = sync_bus.lvl[SI_SCLK];
  wire sen_n_s = sync_bus.lvl[SI_SEN];
  wire serial_in_line_s = sync_bus.lvl[SI_SERIAL_IN_LINE];
  wire [2:0] mode_s = {sync_bus.lvl[SI_M1], sync_bus.lvl[SI_M2], sync_bus.lvl[SI_M3]};
  wire [1:0] lvl_s = sync_bus.lvl[SI_LVL +: 2];

  logic [7:0] reg_file [256];
  logic [31:0] ctrl_ff;
  logic [3:0] rst_cnt_ff;
  logic sclk_d_ff;
  logic [14:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] out_sh_ff;
  logic serial_out_line_ff;
  logic oe_ff;
  logic [7:0] words_ff;
  logic low_speed_ff, ob_ff, lvds_ff, gpd_ff, astby_ff, mux_ff, inval_ff;

  // reset pin high is parallel mode; any high level, short or held, also clears
  wire par_mode = hw_rst_s;
  wire [3:0] nxt_rst_cnt = (!hw_rst_s) ? 4'h0 : (rst_cnt_ff == 4'hF) ? rst_cnt_ff :
                           rst_cnt_ff + 4'h1;
  wire hw_clear = hw_rst_s && (rst_cnt_ff >= HW_RESET_MIN_CNT);

  // serial clock is oversampled: 100 MHz covers a 20 MHz clock whose high and low levels each last over 10 ns
  wire sclk_fall = sclk_d_ff & ~sclk_s;
  wire sclk_rise = ~sclk_d_ff & sclk_s;
  wire frame_on = ~sen_n_s & ~par_mode & ctrl_ff[CTRL_PORT_EN];
  wire fall_act = frame_on & sclk_fall;
  wire [15:0] nxt_word = {shift_ff, serial_in_line_s};
  wire [7:0] wr_addr = nxt_word[15:8];
  wire [7:0] wr_data = nxt_word[7:0];
  wire commit = fall_act && (bit_cnt_ff == LAST_BIT);
  wire readback = reg_file[CFG_ADDR][CFG_READBACK_BIT];
  wire cfg_hit = (wr_addr == CFG_ADDR);
  // the readback bit itself stays writable so the host can leave readback
  wire wr_ok = commit && (!readback || cfg_hit);
  wire sw_reset = wr_ok && cfg_hit && wr_data[CFG_SWRST_BIT];
  wire clear_all = !aresetn || hw_clear || sw_reset;
  wire [7:0] rd_addr = {shift_ff[6:0], serial_in_line_s};
  wire rb_load = fall_act && (bit_cnt_ff == ADDR_DONE) && readback;
  wire rb_shift = frame_on && sclk_rise && (bit_cnt_ff >= OUT_SHIFT_FROM);

  always_ff @(posedge aclk) begin
    if (clear_all) begin
      for (int i = 0; i < 256; i++) begin
        reg_file[i] <= REG_RESET;
      end
    end else if (wr_ok) begin
      reg_file[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt_ff <= 4'h0;
      // idle level of the clock pin, so leaving reset shows no false edge
      sclk_d_ff <= 1'b1;
      shift_ff <= 15'h0000;
      bit_cnt_ff <= 4'h0;
      words_ff <= 8'h00;
    end else begin
      rst_cnt_ff <= nxt_rst_cnt;
      sclk_d_ff <= sclk_s;
      if (!frame_on) begin
        bit_cnt_ff <= 4'h0;
      end else if (fall_act) begin
        shift_ff <= nxt_word[14:0];
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
      if (wr_ok) begin
        words_ff <= words_ff + 8'h01;
      end
    end
  end

  // data changes after rising edges so the host samples it falling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_sh_ff <= 8'h00;
      serial_out_line_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= readback;
      if (!frame_on) begin
        serial_out_line_ff <= 1'b0;
      end else if (rb_load) begin
        out_sh_ff <= reg_file[rd_addr];
        serial_out_line_ff <= reg_file[rd_addr][7];
      end else if (rb_shift) begin
        out_sh_ff <= {out_sh_ff[6:0], 1'b0};
        serial_out_line_ff <= out_sh_ff[6];
      end
    end
  end

  wire acsp_pwr_t pwr = acsp_pwr_decode(mode_s);
  wire nxt_low_speed = par_mode ? sclk_s : reg_file[LOWSPD_ADDR][LOWSPD_BIT];
  wire nxt_ob = par_mode && ((lvl_s == 2'h1) || (lvl_s == 2'h2));
  wire nxt_lvds = par_mode && lvl_s[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_speed_ff <= 1'b0;
      ob_ff <= 1'b0;
      lvds_ff <= 1'b0;
      gpd_ff <= 1'b0;
      astby_ff <= 1'b0;
      mux_ff <= 1'b0;
      inval_ff <= 1'b0;
    end else begin
      low_speed_ff <= nxt_low_speed;
      ob_ff <= nxt_ob;
      lvds_ff <= nxt_lvds;
      gpd_ff <= (pwr == PWR_GLOBAL_PD);
      astby_ff <= (pwr == PWR_A_STANDBY);
      mux_ff <= (pwr == PWR_MUX);
      inval_ff <= (pwr == PWR_UNAVAIL);
    end
  end

  // AXI4-Lite slave: one write and one read in flight
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [AXI_AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic wstrb0_ff;
  logic [1:0] bresp_ff, rresp_ff;

  wire aw_hs = awready_ff & s_axi_awvalid;
  wire w_hs = wready_ff & s_axi_wvalid;
  wire wr_go = !awready_ff && !wready_ff && !bvalid_ff;
  wire wr_ctrl = (awaddr_ff == OFS_CTRL);
  wire ar_hs = arready_ff & s_axi_arvalid;
  wire rd_win = (s_axi_araddr[11:10] == WIN_SEL) && (s_axi_araddr[1:0] == 2'h0);
  wire rd_ctrl = (s_axi_araddr == OFS_CTRL);
  wire rd_stat = (s_axi_araddr == OFS_STATUS);
  wire [31:0] status_w = {8'h00, words_ff, 7'h00, inval_ff, mux_ff, astby_ff, gpd_ff,
                          lvds_ff, ob_ff, low_speed_ff, readback, par_mode};
  wire [31:0] rd_val = rd_ctrl ? ctrl_ff : rd_stat ? status_w :
                       rd_win ? {24'h000000, reg_file[s_axi_araddr[9:2]]} : 32'h00000000;
  wire rd_ok = rd_ctrl | rd_stat | rd_win;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= 32'h00000000;
      wstrb0_ff <= 1'b0;
      ctrl_ff <= CTRL_RESET;
    end else begin
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
        wready_ff <= 1'b0;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
        if (wr_ctrl && wstrb0_ff) begin
          ctrl_ff <= {31'h00000000, wdata_ff[CTRL_PORT_EN]};
        end
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign serial_out_line = serial_out_line_ff;
  assign serial_out_oe = oe_ff;
  assign low_speed_en = low_speed_ff;
  assign offset_binary = ob_ff;
  assign lvds_select = lvds_ff;
  assign global_powerdown = gpd_ff;
  assign chan_a_standby = astby_ff;
  assign mux_mode = mux_ff;
  assign mode_code_invalid = inval_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire [7:0] tgt_val = reg_file[wr_addr];

  a_commit_sixteenth: assert property (commit |-> (bit_cnt_ff == 4'hF) && !sen_n_s
    && $fell(sclk_s)) else $error("commit off sixteenth falling edge");
  a_idle_no_commit: assert property (sen_n_s |-> !commit && !wr_ok)
    else $error("commit while enable high");
  a_partial_dropped: assert property (sen_n_s |=> bit_cnt_ff == 4'h0)
    else $error("partial word survives enable high");
  a_word_lands: assert property (wr_ok && !sw_reset && !hw_clear |=>
    reg_file[$past(wr_addr)] == $past(wr_data)) else $error("word not written");
  a_readback_blocks: assert property (commit && readback && !cfg_hit && !hw_clear |=>
    reg_file[$past(wr_addr)] == $past(tgt_val)) else $error("write in readback");
  a_swreset_clears: assert property (sw_reset && !hw_clear |=> reg_file[CFG_ADDR] == 8'h00
    && reg_file[LOWSPD_ADDR] == 8'h00) else $error("soft reset not cleared");
  a_hwreset_clears: assert property (hw_clear |=> reg_file[CFG_ADDR] == 8'h00)
    else $error("hardware reset not cleared");
  a_hiz_off: assert property (!readback ##1 !readback |-> !serial_out_oe)
    else $error("output driven outside readback");
  a_parallel_lowspd: assert property (par_mode && sclk_s |=> low_speed_en)
    else $error("low-speed not following clock pin");
  a_mux_pins: assert property (mode_s == 3'h7 |=> mux_mode && !global_powerdown)
    else $error("mux mode not entered");
  a_rb_first_bit: assert property (rb_load |=> serial_out_line == $past(reg_file[rd_addr][7]))
    else $error("readback msb wrong");
endmodule // acsp_top

// [verification/acsp_host_model.sv]
// behavioural configuration host that frames words on the serial pins
module acsp_host_model (
  output logic serial_clk_pin,
  output logic serial_enable_n,
  output logic serial_in_line,
  input wire logic serial_out_wire
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] cap = 16'h0000;
  initial begin
    serial_clk_pin = 1'h1;
    serial_enable_n = 1'h1;
    serial_in_line = 1'h0;
  end
  task automatic set_level(input logic v);
    serial_clk_pin <= v;
  endtask
  // clock rests high between frames; released data line flips so no stale level lingers
  task automatic frame(input logic [47:0] b, input int n, input realtime hi, input realtime lo);
    serial_enable_n = 1'h0;
    #(hi);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_line = b[i];
      #(hi);
      serial_clk_pin = 1'h0;
      cap = {cap[14:0], serial_out_wire};
      #(lo);
      serial_clk_pin = 1'h1;
    end
    serial_in_line = ~serial_in_line;
    serial_enable_n = 1'h1;
    #(hi);
  endtask
endmodule // acsp_host_model

// [verification/adc_config_serial_port_bench.sv]
// self-checking bench of the configuration serial port against a behavioural model
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); \
  end \
end
module adc_config_serial_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import acsp_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [AXI_AW-1:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, sen_level_code = 2'h0;
  logic hw_reset_pin = 1'h0, mode_pin_1 = 1'h0, mode_pin_2 = 1'h0, mode_pin_3 = 1'h0;
  wire logic serial_clk_pin, serial_enable_n, serial_in_line;
  logic serial_out_line, serial_out_oe, low_speed_en, offset_binary, lvds_select;
  logic global_powerdown, chan_a_standby, mux_mode, mode_code_invalid;
  wire logic sdo_wire = serial_out_oe ? serial_out_line : 1'hz;
  wire logic [6:0] pins_seen = {low_speed_en, offset_binary, lvds_select, global_powerdown,
    chan_a_standby, mux_mode, mode_code_invalid};
  logic [7:0] mdl [256];
  logic [7:0] ra;
  logic [47:0] b;
  logic [6:0] pe;
  logic [2:0] okc [4] = '{3'h0, 3'h4, 3'h5, 3'h7};
  logic ls;
  int nb;
  int err_count = 0;
  int cmp_count = 0;
  always #5 aclk = ~aclk;
  acsp_top u_acsp_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .hw_reset_pin, .serial_clk_pin, .serial_enable_n, .serial_in_line, .mode_pin_1, .mode_pin_2,
    .mode_pin_3, .sen_level_code, .serial_out_line, .serial_out_oe, .low_speed_en,
    .offset_binary, .lvds_select, .global_powerdown, .chan_a_standby, .mux_mode,
    .mode_code_invalid
  );
  acsp_host_model u_acsp_host_model (.serial_clk_pin, .serial_enable_n, .serial_in_line,
    .serial_out_wire(sdo_wire));
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic lim(input int n);
    if (n > 100) begin
      err_count++;
      $display("ERROR axi wait expected answer seen none");
      summarize();
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; s_axi_bvalid !== 1'h1; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      lim(n);
    end
    s_axi_bready <= 1'h0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; s_axi_rvalid !== 1'h1; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      lim(n);
    end
    s_axi_rready <= 1'h0;
    rd = s_axi_rdata;
    `CHK("rresp", er, s_axi_rresp)
  endtask
  function automatic logic [6:0] exp_pins(logic par, logic sl, int lvl, logic [2:0] c);
    return {sl, par && (lvl == 1 || lvl == 2), par && lvl >= 2, c == 3'h4, c == 3'h5,
      c == 3'h7, !(c inside {3'h0, 3'h4, 3'h5, 3'h7})};
  endfunction
  task automatic model_word(input logic [15:0] w);
    if (w[15:8] == CFG_ADDR && w[CFG_SWRST_BIT]) mdl = '{default: REG_RESET};
    else if (w[15:8] == CFG_ADDR) mdl[0] = w[7:0];
    else if (!mdl[0][CFG_READBACK_BIT]) mdl[w[15:8]] = w[7:0];
  endtask
  task automatic send(logic [47:0] v, int n, realtime hi, realtime lo, logic live);
    u_acsp_host_model.frame(v, n, hi, lo);
    for (int k = 1; k * 16 <= n && live; k++) model_word(16'(v >> (n - 16 * k)));
    repeat (12) @(posedge aclk);
  endtask
  task automatic chk_regs();
    for (int a = 0; a < 256; a++) begin
      axi_rd(12'h400 + 12'(4 * a), RESP_OKAY);
      `CHK("serial reg", {24'h0, mdl[a]}, rd)
    end
    axi_rd(OFS_STATUS, RESP_OKAY);
    `CHK("status", {mdl[0][CFG_READBACK_BIT], 1'h0}, rd[1:0])
    pe = exp_pins(1'h0, mdl[LOWSPD_ADDR][LOWSPD_BIT], 0, {mode_pin_1, mode_pin_2, mode_pin_3});
    `CHK("pins", pe, pins_seen)
    `CHK("sdo enable", mdl[0][CFG_READBACK_BIT], serial_out_oe)
  endtask
  task automatic hw_pulse();
    @(posedge aclk);
    hw_reset_pin <= 1'h1;
    repeat (2) @(posedge aclk);
    hw_reset_pin <= 1'h0;
    mdl = '{default: REG_RESET};
    repeat (8) @(posedge aclk);
  endtask
  initial begin
    mdl = '{default: REG_RESET};
    rd = $urandom(28740);
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(OFS_CTRL, RESP_OKAY);
    `CHK("ctrl", CTRL_RESET, rd)
    axi_rd(12'h008, RESP_SLVERR);
    `CHK("unmapped", 32'h0, rd)
    axi_wr(OFS_STATUS, 32'h0, RESP_SLVERR);
    hw_pulse();
    chk_regs();
    $display("reset and map test done");
    hw_reset_pin <= 1'h1;
    for (int l = 0; l < 4; l++) begin
      for (int c = 0; c < 8; c++) begin
        ls = 1'($urandom);
        @(posedge aclk);
        sen_level_code <= 2'(l);
        {mode_pin_1, mode_pin_2, mode_pin_3} <= 3'(c);
        u_acsp_host_model.set_level(ls);
        repeat (10) @(posedge aclk);
        `CHK("parallel pins", exp_pins(1'h1, ls, l, 3'(c)), pins_seen)
      end
    end
    axi_rd(OFS_STATUS, RESP_OKAY);
    `CHK("parallel flag", 1'h1, rd[ST_PAR])
    @(posedge aclk);
    hw_reset_pin <= 1'h0;
    {mode_pin_1, mode_pin_2, mode_pin_3} <= okc[$urandom % 4];
    u_acsp_host_model.set_level(1'h1);
    repeat (8) @(posedge aclk);
    $display("parallel decode test done");
    for (int i = 0; i < 3; i++) begin
      nb = 32 + $urandom % 16;
      ra = 8'(1 + $urandom % 255);
      b = {ra, 8'($urandom), 8'(1 + $urandom % 255), 24'($urandom)};
      send(b >> (48 - nb), nb, i == 1 ? 40.0 : 62.5, i == 1 ? 85.0 : 62.5, 1'h1);
    end
    send({32'h0, LOWSPD_ADDR, 8'h10}, 16, 62.5, 62.5, 1'h1);
    chk_regs();
    $display("serial write test done");
    send(48'h0001, 16, 62.5, 62.5, 1'h1);
    send({32'h0, ra, 8'h00}, 16, 62.5, 62.5, 1'h1);
    `CHK("readback", mdl[ra], u_acsp_host_model.cap[7:0])
    send({32'h0, ra, ~mdl[ra]}, 16, 62.5, 62.5, 1'h1);
    chk_regs();
    send(48'h0000, 16, 62.5, 62.5, 1'h1);
    `CHK("sdo released", 1'hz, sdo_wire)
    $display("readback test done");
    send(48'h0002, 16, 62.5, 62.5, 1'h1);
    chk_regs();
    $display("software reset test done");
    axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
    send(48'h1234, 16, 62.5, 62.5, 1'h0);
    axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
    send(48'h5678, 16, 62.5, 62.5, 1'h1);
    chk_regs();
    hw_pulse();
    chk_regs();
    $display("port enable and pin reset test done");
    summarize();
  end
endmodule // adc_config_serial_port_bench
